// ### hdl/duregs_map.svh
// Register offsets, field positions and reset values of the serial channel register bank
`ifndef DUREGS_MAP_SVH
`define DUREGS_MAP_SVH
`define DUREGS_ADDR_DATA     3'h0
`define DUREGS_ADDR_MASK     3'h1
`define DUREGS_ADDR_SRC      3'h2
`define DUREGS_ADDR_LCTL     3'h3
`define DUREGS_ADDR_MCTL     3'h4
`define DUREGS_ADDR_LSTAT    3'h5
`define DUREGS_ADDR_MSTAT    3'h6
`define DUREGS_ADDR_SCRATCH  3'h7
`define DUREGS_LCTL_ENH_KEY  8'hBF
`define DUREGS_LCTL_DIV_BIT  7
`define DUREGS_ENH_MODE_BIT  4
`define DUREGS_FRAC_4X_BIT   5
`define DUREGS_FRAC_8X_BIT   4
`define DUREGS_MASK_STD      8'h0F
`define DUREGS_FRAC_STD      8'h0F
`define DUREGS_FRAC_ENH      8'h3F
`define DUREGS_FIFO_CTL_STD  8'hCF
`define DUREGS_MDM_CTL_STD   8'h1F
`define DUREGS_SRC_NONE      6'h01
`define DUREGS_SRC_LINE      6'h06
`define DUREGS_SRC_RXDATA    6'h04
`define DUREGS_SRC_TXEMPTY   6'h02
`define DUREGS_SRC_MODEM     6'h00
`define DUREGS_RST_BYTE      8'h00
`define DUREGS_RST_LCTL      8'h00
`define DUREGS_RST_XCHAR     8'h00
`endif

// ### hdl/duregs_pkg.sv
// Types shared by the serial channel register bank
package duregs_pkg;
	typedef logic [7:0] duregs_byte_t;
	typedef logic [2:0] duregs_addr_t;
endpackage

// ### hdl/duregs_bank.sv
// Host register bank of one serial channel: decode, storage, interrupt masking
`timescale 1ns/100ps
`include "duregs_map.svh"
// What this block does
// RULE_01 - The interrupt mask enables each of the four sources before they reach the interrupt output.
// RULE_02 - The interrupt source register reports which enabled source is pending.
// RULE_03 - Enhanced bits of mask, source, FIFO control, modem control and fraction need enhanced bit 4.
// RULE_04 - The receive holding register is read only and a write there never alters received data.
// RULE_05 - With divisor latch clear, a write at address 0 queues a transmit character while a read there returns received data.
// RULE_06 - The fraction register needs divisor latch set, line control not 0xBF and enhanced bit 4.
// RULE_07 - Reading the line status register clears a pending line status interrupt.
// RULE_08 - Reading the modem status register clears a pending modem status interrupt.
// RULE_09 - With line control at 0xBF, addresses 2 and 4 to 7 reach the enhanced and flow characters.
module duregs_bank (
	input  wire logic                  core_clk,
	input  wire logic                  sys_rst,
	input  wire duregs_pkg::duregs_addr_t host_addr,
	input  wire duregs_pkg::duregs_byte_t host_wdata,
	input  wire logic                  host_wr,
	input  wire logic                  host_rd,
	output duregs_pkg::duregs_byte_t   host_rdata,
	input  wire duregs_pkg::duregs_byte_t rx_holding_reg,
	output logic                       rx_pop,
	output duregs_pkg::duregs_byte_t   tx_holding_reg,
	output logic                       tx_push,
	input  wire logic                  rx_data_ready,
	input  wire logic                  tx_empty,
	input  wire logic                  line_error_event,
	input  wire logic                  modem_change_event,
	input  wire duregs_pkg::duregs_byte_t line_status_reg,
	input  wire duregs_pkg::duregs_byte_t modem_line_status_reg,
	input  wire logic                  fifo_enabled,
	output logic                       irq,
	output duregs_pkg::duregs_byte_t   line_control_reg,
	output duregs_pkg::duregs_byte_t   modem_control_reg,
	output duregs_pkg::duregs_byte_t   fifo_control_reg,
	output logic                       fifo_control_wr,
	output logic [15:0]                divisor,
	output logic [3:0]                 divisor_fraction,
	output logic                       sample_4x,
	output logic                       sample_8x,
	output duregs_pkg::duregs_byte_t   enhanced_function_reg,
	output duregs_pkg::duregs_byte_t   flow_on_char_one,
	output duregs_pkg::duregs_byte_t   flow_on_char_two,
	output duregs_pkg::duregs_byte_t   flow_off_char_one,
	output duregs_pkg::duregs_byte_t   flow_off_char_two
);
	import duregs_pkg::*;

	// Arbitrary identity values, not tied to any part
	localparam duregs_byte_t REVISION_CODE = 8'h01;
	localparam duregs_byte_t PART_IDENTITY = 8'h5A;

	duregs_byte_t lctl_r, lctl_nxt, mask_r, mask_nxt, mctl_r, mctl_nxt;
	duregs_byte_t fctl_r, fctl_nxt, dlo_r, dlo_nxt, dhi_r, dhi_nxt;
	duregs_byte_t frac_r, frac_nxt, enh_r, enh_nxt, scr_r, scr_nxt;
	duregs_byte_t fon1_r, fon1_nxt, fon2_r, fon2_nxt;
	duregs_byte_t foff1_r, foff1_nxt, foff2_r, foff2_nxt;
	duregs_byte_t rdata_r, rdata_nxt, txd_r, txd_nxt;
	logic         line_pend_r, line_pend_nxt, modem_pend_r, modem_pend_nxt;
	logic         enh_key, div_sel, enh_on, frac_sel;
	duregs_byte_t mask_eff, src_val;

	// Mask of writable bits, narrowed while enhanced mode is off
	function automatic duregs_byte_t gated(input duregs_byte_t v, input duregs_byte_t keep,
		input logic en);
		gated = en ? v : (v & keep);
	endfunction

	always_comb begin
		enh_key  = (lctl_r == `DUREGS_LCTL_ENH_KEY);
		div_sel  = lctl_r[`DUREGS_LCTL_DIV_BIT] && !enh_key;
		enh_on   = enh_r[`DUREGS_ENH_MODE_BIT];
		frac_sel = div_sel && enh_on; // RULE_06
		mask_eff = gated(mask_r, `DUREGS_MASK_STD, enh_on); // RULE_03
	end

	// Priority: line status, receive data, transmit empty, modem status
	always_comb begin
		src_val = {fifo_enabled, fifo_enabled, `DUREGS_SRC_NONE}; // RULE_02
		if (mask_eff[2] && line_pend_r)
			src_val[5:0] = `DUREGS_SRC_LINE;
		else if (mask_eff[0] && rx_data_ready)
			src_val[5:0] = `DUREGS_SRC_RXDATA;
		else if (mask_eff[1] && tx_empty)
			src_val[5:0] = `DUREGS_SRC_TXEMPTY;
		else if (mask_eff[3] && modem_pend_r)
			src_val[5:0] = `DUREGS_SRC_MODEM;
	end

	always_comb begin
		irq = (mask_eff[0] && rx_data_ready) || (mask_eff[1] && tx_empty) ||
			(mask_eff[2] && line_pend_r) || (mask_eff[3] && modem_pend_r); // RULE_01
	end

	always_comb begin
		lctl_nxt = lctl_r; mask_nxt = mask_r; mctl_nxt = mctl_r; fctl_nxt = fctl_r;
		dlo_nxt = dlo_r; dhi_nxt = dhi_r; frac_nxt = frac_r; enh_nxt = enh_r;
		scr_nxt = scr_r; fon1_nxt = fon1_r; fon2_nxt = fon2_r;
		foff1_nxt = foff1_r; foff2_nxt = foff2_r; txd_nxt = txd_r;
		rdata_nxt = rdata_r;
		tx_push = 1'b0;
		rx_pop = 1'b0;
		fifo_control_wr = 1'b0;
		// Set wins over a clearing read in the same cycle
		line_pend_nxt = line_error_event ||
			(line_pend_r && !(host_rd && host_addr == `DUREGS_ADDR_LSTAT && !enh_key)); // RULE_07
		modem_pend_nxt = modem_change_event ||
			(modem_pend_r && !(host_rd && host_addr == `DUREGS_ADDR_MSTAT && !enh_key)); // RULE_08
		if (host_wr) begin
			unique case (host_addr)
				`DUREGS_ADDR_DATA: begin
					if (div_sel)
						dlo_nxt = host_wdata;
					else if (!lctl_r[`DUREGS_LCTL_DIV_BIT]) begin
						txd_nxt = host_wdata; // RULE_04 RULE_05
						tx_push = 1'b1;
					end
				end
				`DUREGS_ADDR_MASK: begin
					if (div_sel)
						dhi_nxt = host_wdata;
					else if (!lctl_r[`DUREGS_LCTL_DIV_BIT])
						mask_nxt = gated(host_wdata, `DUREGS_MASK_STD, enh_on); // RULE_03
				end
				`DUREGS_ADDR_SRC: begin
					if (enh_key)
						enh_nxt = host_wdata; // RULE_09
					else if (frac_sel)
						frac_nxt = host_wdata & `DUREGS_FRAC_ENH; // RULE_06
					else if (!div_sel) begin
						fctl_nxt = gated(host_wdata, `DUREGS_FIFO_CTL_STD, enh_on); // RULE_03
						fifo_control_wr = 1'b1;
					end
				end
				`DUREGS_ADDR_LCTL: lctl_nxt = host_wdata;
				`DUREGS_ADDR_MCTL: begin
					if (enh_key)
						fon1_nxt = host_wdata; // RULE_09
					else
						mctl_nxt = gated(host_wdata, `DUREGS_MDM_CTL_STD, enh_on); // RULE_03
				end
				`DUREGS_ADDR_LSTAT: if (enh_key) fon2_nxt = host_wdata;
				`DUREGS_ADDR_MSTAT: if (enh_key) foff1_nxt = host_wdata;
				`DUREGS_ADDR_SCRATCH: begin
					if (enh_key)
						foff2_nxt = host_wdata;
					else
						scr_nxt = host_wdata;
				end
			endcase
		end
		if (host_rd) begin
			unique case (host_addr)
				`DUREGS_ADDR_DATA: begin
					if (enh_key || div_sel)
						rdata_nxt = (dlo_r == `DUREGS_RST_BYTE && dhi_r == `DUREGS_RST_BYTE) ?
							REVISION_CODE : dlo_r;
					else begin
						rdata_nxt = rx_holding_reg; // RULE_05
						rx_pop = 1'b1;
					end
				end
				`DUREGS_ADDR_MASK: begin
					if (enh_key || div_sel)
						rdata_nxt = (dlo_r == `DUREGS_RST_BYTE && dhi_r == `DUREGS_RST_BYTE) ?
							PART_IDENTITY : dhi_r;
					else
						rdata_nxt = mask_eff;
				end
				`DUREGS_ADDR_SRC: begin
					if (enh_key)
						rdata_nxt = enh_r;
					else if (frac_sel)
						rdata_nxt = frac_r;
					else
						rdata_nxt = enh_on ? src_val : (src_val & 8'hCF); // RULE_02 RULE_03
				end
				`DUREGS_ADDR_LCTL:    rdata_nxt = lctl_r;
				`DUREGS_ADDR_MCTL:    rdata_nxt = enh_key ? fon1_r :
					gated(mctl_r, `DUREGS_MDM_CTL_STD, enh_on);
				`DUREGS_ADDR_LSTAT:   rdata_nxt = enh_key ? fon2_r : line_status_reg;
				`DUREGS_ADDR_MSTAT:   rdata_nxt = enh_key ? foff1_r : modem_line_status_reg;
				`DUREGS_ADDR_SCRATCH: rdata_nxt = enh_key ? foff2_r : scr_r;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			lctl_r <= `DUREGS_RST_LCTL;  mask_r <= `DUREGS_RST_BYTE;
			mctl_r <= `DUREGS_RST_BYTE;  fctl_r <= `DUREGS_RST_BYTE;
			dlo_r <= `DUREGS_RST_BYTE;   dhi_r <= `DUREGS_RST_BYTE;
			frac_r <= `DUREGS_RST_BYTE;  enh_r <= `DUREGS_RST_BYTE;
			scr_r <= `DUREGS_RST_BYTE;   txd_r <= `DUREGS_RST_BYTE;
			fon1_r <= `DUREGS_RST_XCHAR; fon2_r <= `DUREGS_RST_XCHAR;
			foff1_r <= `DUREGS_RST_XCHAR; foff2_r <= `DUREGS_RST_XCHAR;
			rdata_r <= `DUREGS_RST_BYTE;
			line_pend_r <= 1'b0;
			modem_pend_r <= 1'b0;
		end else begin
			lctl_r <= lctl_nxt;   mask_r <= mask_nxt;
			mctl_r <= mctl_nxt;   fctl_r <= fctl_nxt;
			dlo_r <= dlo_nxt;     dhi_r <= dhi_nxt;
			frac_r <= frac_nxt;   enh_r <= enh_nxt;
			scr_r <= scr_nxt;     txd_r <= txd_nxt;
			fon1_r <= fon1_nxt;   fon2_r <= fon2_nxt;
			foff1_r <= foff1_nxt; foff2_r <= foff2_nxt;
			rdata_r <= rdata_nxt;
			line_pend_r <= line_pend_nxt;
			modem_pend_r <= modem_pend_nxt;
		end
	end

	// Enhanced fields are withheld from the datapath while bit 4 is low
	always_comb begin
		host_rdata            = rdata_r;
		tx_holding_reg        = txd_r;
		line_control_reg      = lctl_r;
		modem_control_reg     = gated(mctl_r, `DUREGS_MDM_CTL_STD, enh_on); // RULE_03
		fifo_control_reg      = gated(fctl_r, `DUREGS_FIFO_CTL_STD, enh_on);
		divisor               = {dhi_r, dlo_r};
		divisor_fraction      = enh_on ? frac_r[3:0] : 4'h0;
		sample_4x             = enh_on && frac_r[`DUREGS_FRAC_4X_BIT]; // RULE_06
		sample_8x             = enh_on && frac_r[`DUREGS_FRAC_8X_BIT];
		enhanced_function_reg = enh_r;
		flow_on_char_one      = fon1_r;
		flow_on_char_two      = fon2_r;
		flow_off_char_one     = foff1_r;
		flow_off_char_two     = foff2_r;
	end
endmodule // duregs_bank

// ### verification/duregs_bank_chk.sv
// Assertions on the host side of the serial channel register bank
`timescale 1ns/100ps
module duregs_bank_chk (
	input	wire logic		core_clk,
	input	wire logic		sys_rst,
	input	wire logic [2:0]	host_addr,
	input	wire logic [7:0]	host_wdata,
	input	wire logic		host_wr,
	input	wire logic		host_rd,
	input	wire logic [7:0]	host_rdata,
	input	wire logic [7:0]	rx_holding_reg,
	input	wire logic		rx_pop,
	input	wire logic [7:0]	tx_holding_reg,
	input	wire logic [7:0]	line_status_reg,
	input	wire logic [7:0]	modem_line_status_reg,
	input	wire logic		irq,
	input	wire logic [7:0]	line_control_reg,
	input	wire logic [3:0]	divisor_fraction,
	input	wire logic		sample_4x,
	input	wire logic		sample_8x,
	input	wire logic [7:0]	enhanced_function_reg
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	logic	dm, key, msk_r, msk_nxt;
	assign dm = !line_control_reg[7];
	assign key = line_control_reg == 8'hBF;
	// Until a mask write is seen no source can reach irq
	always_comb msk_nxt = msk_r | (host_wr && host_addr == 3'h1 && dm);
	always_ff @(posedge core_clk) msk_r <= sys_rst ? 1'b0 : msk_nxt;
	irq_masked_a: assert property (!msk_r |-> !irq) else $error("irq unmasked");
	rx_pop_a: assert property (host_rd && host_addr == 3'h0 && dm |-> rx_pop) else $error("no pop");
	pop_read_a: assert property (rx_pop |-> host_rd) else $error("pop without read");
	rx_read_a: assert property (host_rd && host_addr == 3'h0 && dm |=>
		host_rdata == $past(rx_holding_reg)) else $error("rx data");
	tx_load_a: assert property (host_wr && host_addr == 3'h0 && dm |=>
		tx_holding_reg == $past(host_wdata)) else $error("tx data");
	frac_gate_a: assert property (!enhanced_function_reg[4] |->
		{sample_4x, sample_8x, divisor_fraction} == 6'h00) else $error("frac gate");
	frac_write_a: assert property (host_wr && host_addr == 3'h2 && !dm && !key &&
		enhanced_function_reg[4] |=> {sample_4x, sample_8x, divisor_fraction} ==
		$past(host_wdata[5:0])) else $error("frac write");
	line_stat_a: assert property (host_rd && host_addr == 3'h5 && !key |=>
		host_rdata == $past(line_status_reg)) else $error("line status read");
	modem_stat_a: assert property (host_rd && host_addr == 3'h6 && !key |=>
		host_rdata == $past(modem_line_status_reg)) else $error("modem status read");
	enh_map_a: assert property (host_wr && host_addr == 3'h2 && key |=>
		enhanced_function_reg == $past(host_wdata)) else $error("enhanced write");
	cover property (irq ##1 !irq);
	cover property (sample_4x && sample_8x);
	cover property (key && host_wr);
endmodule // duregs_bank_chk
bind duregs_bank duregs_bank_chk chk (.*);

// ### verification/duregs_host.sv
// Host processor model driving the register bank bus
`timescale 1ns/100ps
module duregs_host (
	input	wire logic		core_clk,
	input	wire logic [7:0]	host_rdata,
	output	logic [2:0]		host_addr,
	output	logic [7:0]		host_wdata,
	output	logic			host_wr,
	output	logic			host_rd
);
	initial begin
		host_addr = 3'h0;
		host_wdata = 8'h00;
		host_wr = 1'b0;
		host_rd = 1'b0;
	end
	// Idle address and data lines show inverted values so stale data never looks valid
	task automatic xfer(input logic [2:0] a, input logic [7:0] d, input logic w);
		@(posedge core_clk);
		host_addr <= a;
		host_wdata <= d;
		host_wr <= w;
		host_rd <= !w;
		@(posedge core_clk);
		host_addr <= ~a;
		host_wdata <= ~d;
		host_wr <= 1'b0;
		host_rd <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		xfer(a, 8'h00, 1'b0);
		@(posedge core_clk);
		d = host_rdata;
	endtask
endmodule // duregs_host

// ### verification/testbench.sv
// Self-checking bench of the serial channel register bank
`timescale 1ns/100ps
module testbench;
	import duregs_pkg::*;
	typedef struct {logic [2:0] a; logic [7:0] d; logic [7:0] e;} duregs_row_t;
	logic	core_clk = 0, sys_rst = 1, rx_data_ready = 0, tx_empty = 0, line_error_event = 0;
	logic	modem_change_event = 0, fifo_enabled = 1, host_wr, host_rd, rx_pop, tx_push, irq;
	logic	fifo_control_wr, sample_4x, sample_8x;
	logic [15:0]	divisor;
	logic [3:0]	divisor_fraction;
	duregs_addr_t	host_addr;
	duregs_byte_t	host_wdata, host_rdata, tx_holding_reg, line_control_reg, rd_v;
	duregs_byte_t	modem_control_reg, fifo_control_reg, enhanced_function_reg;
	duregs_byte_t	flow_on_char_one, flow_on_char_two, flow_off_char_one, flow_off_char_two;
	duregs_byte_t	rx_holding_reg = 8'h96, line_status_reg = 8'h61, modem_line_status_reg = 8'hB0;
	int	err_count = 0, total_checks = 0, cyc = 0;
	duregs_row_t	rows[4] = '{'{3'h7, 8'hA5, 8'hA5}, '{3'h1, 8'hFF, 8'h0F},
		'{3'h4, 8'hFF, 8'h1F}, '{3'h3, 8'h03, 8'h03}};
	always #5 core_clk = ~core_clk;
	duregs_bank uut (.*);
	duregs_host host (.*);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_count++;
			test_done();
		end
	end
	initial begin
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		#1 chk({host_rdata, irq}, 9'h000);
		foreach (rows[i]) begin
			host.xfer(rows[i].a, rows[i].d, 1'b1);
			host.rd(rows[i].a, rd_v);
			chk(rd_v, rows[i].e);
		end
		host.xfer(3'h0, 8'h3C, 1'b1);
		host.rd(3'h0, rd_v);
		chk({rd_v, tx_holding_reg}, 16'h963C);
		chk({line_control_reg, modem_control_reg}, 16'h031F);
		host.xfer(3'h2, 8'hFF, 1'b1);
		chk(fifo_control_reg, 8'hCF);
		$display("table and data tests done");
		host.xfer(3'h1, 8'h00, 1'b1);
		@(posedge core_clk);
		rx_data_ready <= 1'b1;
		tx_empty <= 1'b1;
		#1 chk(irq, 1'b0);
		host.xfer(3'h1, 8'h01, 1'b1);
		host.rd(3'h2, rd_v);
		chk({rd_v, irq}, {8'hC4, 1'b1});
		host.xfer(3'h1, 8'h02, 1'b1);
		host.rd(3'h2, rd_v);
		chk(rd_v, 8'hC2);
		host.xfer(3'h1, 8'h0C, 1'b1);
		@(posedge core_clk);
		line_error_event <= 1'b1;
		@(posedge core_clk);
		line_error_event <= 1'b0;
		modem_change_event <= 1'b1;
		@(posedge core_clk);
		modem_change_event <= 1'b0;
		host.rd(3'h2, rd_v);
		chk(rd_v, 8'hC6);
		host.rd(3'h5, rd_v);
		host.rd(3'h2, rd_v);
		chk(rd_v, 8'hC0);
		host.rd(3'h6, rd_v);
		host.rd(3'h2, rd_v);
		chk({rd_v, irq}, {8'hC1, 1'b0});
		$display("interrupt tests done");
		host.xfer(3'h3, 8'h80, 1'b1);
		host.rd(3'h0, rd_v);
		chk(rd_v, 8'h01);
		host.rd(3'h1, rd_v);
		chk(rd_v, 8'h5A);
		host.xfer(3'h2, 8'h3B, 1'b1);
		chk(divisor_fraction, 4'h0);
		host.xfer(3'h0, 8'h34, 1'b1);
		host.xfer(3'h1, 8'h12, 1'b1);
		chk(divisor, 16'h1234);
		host.xfer(3'h3, 8'hBF, 1'b1);
		host.xfer(3'h2, 8'h10, 1'b1);
		host.xfer(3'h4, 8'h11, 1'b1);
		host.xfer(3'h7, 8'h14, 1'b1);
		chk({flow_on_char_one, flow_off_char_two}, 16'h1114);
		chk(enhanced_function_reg, 8'h10);
		host.xfer(3'h3, 8'h80, 1'b1);
		host.xfer(3'h2, 8'h3B, 1'b1);
		chk({sample_4x, sample_8x, divisor_fraction}, 6'h3B);
		$display("divisor and enhanced tests done");
		test_done();
	end
endmodule // testbench
